// *** verilog/host_read_select_port.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Inside the read code, the three address lines pick which byte is returned.
// - The chosen byte is driven onto the data bus when the read strobe falls.
// - Read address 111 ignores the read code and returns the status byte.
// - Code 000 gives I and Q low/high, code 001 magnitude then phase, code 010 frequency.
// - Code 100 returns the 24-bit level detector result, low byte first, over addresses 0 to 2.
// - Code 101 addresses 0 and 1 give the 11-bit gain mantissa and four shift bits.
// - Code 101 addresses 2 and 3 give the timing error bytes with no stabilisation.
// - Status bits 6 to 4 show the FIFO depth while in FIFO buffer mode.
// - Status bit 3 is high while the FIFO is empty.
// - Status bit 2 is high while the FIFO is full.
// - Status bit 1 is low when the threshold or snapshot count is reached.
// - Status bit 0 is high when the level detector result is ready.
module host_read_select_port (
  // Clock, enable and reset
  input  wire logic        core_clk,
  input  wire logic        clk_en,
  input  wire logic        rst_n,
  // Host pins
  input  wire logic [2:0]  host_addr,
  input  wire logic        host_wr_n,
  input  wire logic        host_rd_n,
  input  wire logic [7:0]  host_data_in,
  output var  logic [7:0]  host_data_out,
  output logic             host_data_oe_n,
  // Buffered output words
  input  wire logic [15:0] buf_i,
  input  wire logic [15:0] buf_q,
  input  wire logic [15:0] buf_magnitude,
  input  wire logic [15:0] buf_phase,
  input  wire logic [15:0] buf_freq,
  // Level detector and gain
  input  wire logic [23:0] level_result,
  input  wire logic        level_done_a,
  input  wire logic [10:0] agc_mantissa,
  input  wire logic [3:0]  agc_shift,
  input  wire logic [15:0] timing_error,
  // Buffer state
  input  wire logic        fifo_mode,
  input  wire logic [2:0]  fifo_depth,
  input  wire logic        fifo_empty,
  input  wire logic        fifo_full,
  input  wire logic        output_threshold_flag_n,
  // Sampling strobe towards the gain block
  output logic             agc_sample_pulse
);
  logic       rst_meta;
  logic       rst_sync_n;
  logic [4:0] pins_sync;
  logic [2:0] addr_sync;
  logic [7:0] data_sync;
  logic       wr_n_d;
  logic       rd_n_d;
  logic [2:0] read_source_select;
  logic [7:0] next_data_out;
  logic [7:0] status_byte;
  logic [7:0] code_byte;
  logic [7:0] agc_hi;
  logic [7:0] agc_lo;
  logic [2:0] depth_field;
  logic       wr_rise;
  logic       rd_fall;
  logic       sample_q;
  logic       select_write;
  logic       agc_write;
  // Strobes and the low-active flag cross inverted, so a cleared synchroniser reads idle
  wire        wr_n_s   = !pins_sync[0];
  wire        rd_n_s   = !pins_sync[1];
  wire        done_s   = pins_sync[2];
  wire        thresh_n = !pins_sync[3];
  wire        mode_s   = pins_sync[4];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Strobes, address and data are all pins from the host domain
  pin_sync #(.WIDTH(16)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_sync_n),
    .clk_en   (clk_en),
    .async_in ({host_data_in, host_addr, fifo_mode, ~output_threshold_flag_n,
                level_done_a, ~host_rd_n, ~host_wr_n}),
    .sync_out ({data_sync, addr_sync, pins_sync})
  );

  assign wr_rise = wr_n_s && !wr_n_d;
  assign rd_fall = !rd_n_s && rd_n_d;
  assign select_write = wr_rise && (addr_sync == host_read_pkg::ADDR_READ_SELECT);
  assign agc_write    = wr_rise && (addr_sync == host_read_pkg::ADDR_AGC_SAMPLE);

  // Status byte; depth only shown in FIFO mode
  assign depth_field = mode_s ? fifo_depth : 3'h0;
  assign status_byte = {1'b0,
                        depth_field,
                        fifo_empty,
                        fifo_full,
                        thresh_n,
                        done_s};

  localparam int AGC_MANT_W_HI = host_read_pkg::AGC_MANT_W - 1;

  // The high gain byte only has room for a pad bit, the shift bits and three mantissa bits
  if (host_read_pkg::AGC_SHIFT_W + host_read_pkg::AGC_MANT_W != 15)
  begin
    $error("gain fields do not fit the two gain bytes");
  end
  if (host_read_pkg::LEVEL_W != 24)
  begin
    $error("level result must span exactly three bytes");
  end

  assign agc_lo = agc_mantissa[7:0];
  assign agc_hi = {1'b0, agc_shift, agc_mantissa[AGC_MANT_W_HI:8]};

  always_comb
  begin
    code_byte = host_read_pkg::UNUSED_BYTE;
    case (read_source_select)
      host_read_pkg::CODE_IQ:
        case (addr_sync)
          host_read_pkg::BYTE_0: code_byte = buf_i[7:0];
          host_read_pkg::BYTE_1: code_byte = buf_i[15:8];
          host_read_pkg::BYTE_2: code_byte = buf_q[7:0];
          host_read_pkg::BYTE_3: code_byte = buf_q[15:8];
          default:               code_byte = host_read_pkg::UNUSED_BYTE;
        endcase
      host_read_pkg::CODE_MAGNITUDE_PHASE:
        case (addr_sync)
          host_read_pkg::BYTE_0: code_byte = buf_magnitude[7:0];
          host_read_pkg::BYTE_1: code_byte = buf_magnitude[15:8];
          host_read_pkg::BYTE_2: code_byte = buf_phase[7:0];
          host_read_pkg::BYTE_3: code_byte = buf_phase[15:8];
          default:               code_byte = host_read_pkg::UNUSED_BYTE;
        endcase
      host_read_pkg::CODE_FREQ:
        case (addr_sync)
          host_read_pkg::BYTE_0: code_byte = buf_freq[7:0];
          host_read_pkg::BYTE_1: code_byte = buf_freq[15:8];
          default:               code_byte = host_read_pkg::UNUSED_BYTE;
        endcase
      host_read_pkg::CODE_LEVEL:
        case (addr_sync)
          host_read_pkg::BYTE_0: code_byte = level_result[7:0];
          host_read_pkg::BYTE_1: code_byte = level_result[15:8];
          host_read_pkg::BYTE_2: code_byte = level_result[23:16];
          default:               code_byte = host_read_pkg::UNUSED_BYTE;
        endcase
      host_read_pkg::CODE_AGC_TIMING:
        case (addr_sync)
          host_read_pkg::BYTE_0: code_byte = agc_lo;
          host_read_pkg::BYTE_1: code_byte = agc_hi;
          // Live value, bytes of one word may straddle an update
          host_read_pkg::BYTE_2: code_byte = timing_error[7:0];
          host_read_pkg::BYTE_3: code_byte = timing_error[15:8];
          default:               code_byte = host_read_pkg::UNUSED_BYTE;
        endcase
      default: code_byte = host_read_pkg::UNUSED_BYTE;
    endcase
  end

  // Address 111 overrides the stored code
  assign next_data_out = (addr_sync == host_read_pkg::ADDR_STATUS) ?
                         status_byte : code_byte;

  // Strobe history; resets to the idle level so no false edge follows reset
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wr_n_d <= 1'b1;
      rd_n_d <= 1'b1;
    end
    else if (clk_en)
    begin
      wr_n_d <= wr_n_s;
      rd_n_d <= rd_n_s;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      read_source_select <= host_read_pkg::READ_CODE_RESET;
    else if (clk_en && select_write)
      read_source_select <= data_sync[2:0];
  end

  // Gain sample strobe, one cycle per write to the sample address
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      sample_q <= 1'b0;
    else if (clk_en)
      sample_q <= agc_write;
  end

  // One capture per falling edge; each byte needs its own strobe
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      host_data_out <= host_read_pkg::DATA_RESET;
    else if (clk_en && rd_fall)
      host_data_out <= next_data_out;
  end

  assign agc_sample_pulse = sample_q && clk_en;
  // Drive only while read strobe is low and the byte has been captured
  assign host_data_oe_n   = rd_n_s || rd_n_d;
endmodule
`default_nettype wire

// *** verilog/host_read_pkg.sv ***
package host_read_pkg;
  // Host address map
  localparam logic [2:0] ADDR_READ_SELECT   = 3'h5;
  localparam logic [2:0] ADDR_AGC_SAMPLE    = 3'h2;
  localparam logic [2:0] ADDR_STATUS        = 3'h7;
  // Read codes
  localparam logic [2:0] CODE_IQ            = 3'h0;
  localparam logic [2:0] CODE_MAGNITUDE_PHASE = 3'h1;
  localparam logic [2:0] CODE_FREQ          = 3'h2;
  localparam logic [2:0] CODE_LEVEL         = 3'h4;
  localparam logic [2:0] CODE_AGC_TIMING    = 3'h5;
  localparam logic [2:0] READ_CODE_RESET    = 3'h0;
  // Byte addresses within a code
  localparam logic [2:0] BYTE_0             = 3'h0;
  localparam logic [2:0] BYTE_1             = 3'h1;
  localparam logic [2:0] BYTE_2             = 3'h2;
  localparam logic [2:0] BYTE_3             = 3'h3;
  // Status byte field positions
  localparam int STAT_DEPTH_LSB             = 4;
  localparam int STAT_EMPTY                 = 3;
  localparam int STAT_FULL                  = 2;
  localparam int STAT_THRESH_N              = 1;
  localparam int STAT_LEVEL_DONE            = 0;
  // Widths and fill values
  localparam int AGC_MANT_W                 = 11;
  localparam int AGC_SHIFT_W                = 4;
  localparam int LEVEL_W                    = 24;
  localparam int DEPTH_W                    = 3;
  localparam logic [7:0] UNUSED_BYTE        = 8'h00;
  localparam logic [7:0] DATA_RESET         = 8'h00;
endpackage

// *** verilog/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for a bundle of pin levels
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else if (clk_en)
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// *** verification/host_read_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_read_properties (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Host pins
  input wire logic [2:0] host_addr,
  input wire logic       host_wr_n,
  input wire logic       host_rd_n,
  input wire logic [7:0] host_data_out,
  input wire logic       host_data_oe_n,
  // Status sources and gain strobe
  input wire logic       level_done_a,
  input wire logic       fifo_mode,
  input wire logic       fifo_empty,
  input wire logic       fifo_full,
  input wire logic       output_threshold_flag_n,
  input wire logic       agc_sample_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire at_stat = host_addr == host_read_pkg::ADDR_STATUS;
  wire at_agc  = host_addr == host_read_pkg::ADDR_AGC_SAMPLE;
  AST_IDLE_RELEASE: assert property (host_rd_n [*4] |-> host_data_oe_n)
    else $error("data bus driven while read strobe idle");
  AST_ANSWER_TIME: assert property ($fell(host_rd_n) |-> ##[1:5] !host_data_oe_n)
    else $error("no answer to read strobe");
  AST_DATA_HOLD: assert property (
    !host_data_oe_n && !$past(host_data_oe_n) |-> $stable(host_data_out))
    else $error("read byte changed while driven");
  AST_STAT_FLAGS: assert property (
    $fell(host_data_oe_n) && at_stat |->
      host_data_out[3:0] == {fifo_empty, fifo_full, output_threshold_flag_n, level_done_a})
    else $error("status flags wrong");
  AST_DEPTH_OFF: assert property (
    $fell(host_data_oe_n) && at_stat && !fifo_mode |-> host_data_out[7:4] == 4'h0)
    else $error("depth shown outside fifo mode");
  AST_PULSE_ONE: assert property (agc_sample_pulse |=> !agc_sample_pulse)
    else $error("gain sample pulse too long");
  AST_PULSE_CAUSE: assert property ($rose(host_wr_n) && at_agc |-> ##[1:6] agc_sample_pulse)
    else $error("gain sample pulse missing");
  AST_NO_STRAY: assert property ($rose(host_wr_n) && !at_agc |=> !agc_sample_pulse [*6])
    else $error("gain sample pulse from other write");
  COV_STATUS: cover property ($fell(host_data_oe_n) && at_stat);
  COV_AGC: cover property (agc_sample_pulse);
  COV_BACK: cover property ($rose(host_data_oe_n) ##[4:8] $fell(host_data_oe_n));
endmodule
bind host_read_select_port host_read_properties i_host_read_properties (
  .core_clk, .rst_n, .host_addr, .host_wr_n, .host_rd_n, .host_data_out, .host_data_oe_n,
  .level_done_a, .fifo_mode, .fifo_empty, .fifo_full, .output_threshold_flag_n,
  .agc_sample_pulse);
`default_nettype wire

// *** verification/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic       core_clk,
  // Device answer
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe_n,
  // Host strobes and buses
  output var  logic [2:0] host_addr = 3'h0,
  output var  logic       host_wr_n = 1'b1,
  output var  logic       host_rd_n = 1'b1,
  output var  logic [7:0] host_data_in = 8'h00
);
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_addr <= a;
    host_data_in <= d;
    repeat (3) @(posedge core_clk);
    host_wr_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    host_wr_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    // Released bus shows the inverse so a late capture cannot match by luck
    host_data_in <= ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(posedge core_clk);
    host_addr <= a;
    repeat (3) @(posedge core_clk);
    host_rd_n <= 1'b0;
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (host_data_oe_n !== 1'b0 && n < 10);
    ok = host_data_oe_n === 1'b0;
    d = host_data_out;
    @(posedge core_clk);
    host_rd_n <= 1'b1;
    repeat (5) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// *** verification/test_host_read_select_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_host_read_select_port;
  logic        core_clk = 1'b0, rst_n = 1'b0;
  logic [15:0] buf_i = 16'h1a2b, buf_q = 16'h3c4d, buf_magnitude = 16'h5e6f;
  logic [15:0] buf_phase = 16'h7081, buf_freq = 16'h92a3, timing_error = 16'hb4c5;
  logic [23:0] level_result = 24'h32_1af5;
  logic [10:0] agc_mantissa = 11'h5c3;
  logic [3:0]  agc_shift = 4'h9;
  logic [2:0]  fifo_depth = 3'h5;
  logic        level_done_a = 1'b1, fifo_mode = 1'b1, fifo_empty = 1'b0;
  logic        fifo_full = 1'b1, output_threshold_flag_n = 1'b0;
  wire logic [2:0] host_addr;
  wire logic [7:0] host_data_in, host_data_out;
  wire logic       host_wr_n, host_rd_n, host_data_oe_n, agc_sample_pulse;
  int          error_cnt = 0, n_tests = 0;
  int          pulse_cnt = 0;
  logic        clk_en = 1'b1;
  always #5 core_clk = ~core_clk;
  // Counts gain sample strobes so each write can be checked for its effect
  always @(posedge core_clk)
    if (agc_sample_pulse === 1'b1)
      pulse_cnt <= pulse_cnt + 1;
  host_read_select_port i_host_read_select_port (.core_clk, .clk_en, .rst_n,
    .host_addr, .host_wr_n, .host_rd_n, .host_data_in, .host_data_out, .host_data_oe_n,
    .buf_i, .buf_q, .buf_magnitude, .buf_phase, .buf_freq, .level_result, .level_done_a,
    .agc_mantissa, .agc_shift, .timing_error, .fifo_mode, .fifo_depth, .fifo_empty,
    .fifo_full, .output_threshold_flag_n, .agc_sample_pulse);
  host_model i_host_model (.core_clk, .host_data_out, .host_data_oe_n, .host_addr,
    .host_wr_n, .host_rd_n, .host_data_in);
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(string nm, logic [7:0] e, logic [7:0] s);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rb(logic [2:0] a, logic [7:0] e, string nm);
    logic [7:0] d;
    logic       ok;
    i_host_model.rd(a, d, ok);
    cmp(nm, e, ok ? d : 8'hxx);
    if (!ok)
      end_of_test();
  endtask
  task automatic sel(logic [2:0] c);
    i_host_model.wr(host_read_pkg::ADDR_READ_SELECT, {5'h00, c});
  endtask
  task automatic t_buffers;
    sel(host_read_pkg::CODE_IQ);
    rb(3'h0, buf_i[7:0], "i_lo");
    rb(3'h1, buf_i[15:8], "i_hi");
    rb(3'h2, buf_q[7:0], "q_lo");
    rb(3'h3, buf_q[15:8], "q_hi");
    sel(host_read_pkg::CODE_MAGNITUDE_PHASE);
    rb(3'h0, buf_magnitude[7:0], "magnitude_lo");
    rb(3'h1, buf_magnitude[15:8], "magnitude_hi");
    rb(3'h2, buf_phase[7:0], "ph_lo");
    rb(3'h3, buf_phase[15:8], "ph_hi");
    sel(host_read_pkg::CODE_FREQ);
    rb(3'h1, buf_freq[15:8], "fr_hi");
    rb(3'h0, buf_freq[7:0], "fr_lo");
    rb(3'h2, host_read_pkg::UNUSED_BYTE, "fr_gap");
    $display("t_buffers done");
  endtask
  task automatic t_level_agc;
    logic [2:0] unused_codes [3] = '{3'h3, 3'h6, 3'h7};
    int         pulse_base;
    sel(host_read_pkg::CODE_LEVEL);
    rb(3'h0, 8'hf5, "lvl_0");
    rb(3'h1, 8'h1a, "lvl_1");
    rb(3'h2, 8'h32, "lvl_2");
    rb(3'h3, host_read_pkg::UNUSED_BYTE, "lvl_gap");
    pulse_base = pulse_cnt;
    i_host_model.wr(host_read_pkg::ADDR_AGC_SAMPLE, 8'h00);
    sel(host_read_pkg::CODE_AGC_TIMING);
    cmp("agc_pulses", 8'h01, 8'(pulse_cnt - pulse_base));
    rb(3'h0, agc_mantissa[7:0], "agc_lo");
    rb(3'h1, {1'b0, agc_shift, agc_mantissa[10:8]}, "agc_hi");
    rb(3'h2, timing_error[7:0], "te_lo");
    rb(3'h3, timing_error[15:8], "te_hi");
    foreach (unused_codes[k])
    begin
      sel(unused_codes[k]);
      rb(3'h0, host_read_pkg::UNUSED_BYTE, "no_code");
    end
    $display("t_level_agc done");
  endtask
  task automatic t_status;
    sel(host_read_pkg::CODE_LEVEL);
    rb(3'h7, 8'h55, "stat_fifo");
    @(posedge core_clk);
    {fifo_mode, fifo_empty, fifo_full} <= 3'h2;
    {output_threshold_flag_n, level_done_a} <= 2'h2;
    rb(3'h7, 8'h0a, "stat_plain");
    $display("t_status done");
  endtask
  task automatic t_freeze;
    @(posedge core_clk);
    clk_en <= 1'b0;
    sel(host_read_pkg::CODE_IQ);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rb(3'h0, level_result[7:0], "frozen_sel");
    sel(host_read_pkg::CODE_IQ);
    rb(3'h0, buf_i[7:0], "thawed_sel");
    $display("t_freeze done");
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_buffers();
    t_level_agc();
    t_status();
    t_freeze();
    end_of_test();
  end
endmodule
`default_nettype wire
